// File: sim/sar_adc_conversion_control_asserts.sv
// Checker for the converter control block.
// Assumes one clock domain; bound to the top module below.
module sar_adc_conversion_control_asserts (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // System and core
  input wire logic       standby_i,
  input wire logic       int_enable_i,
  input wire logic       track_o,
  input wire logic       convert_o,
  input wire logic       power_down_o,
  input wire logic       differential_o,
  input wire logic [4:0] positive_input_select_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ********
  // Properties
  // ********
  // Enabled, idle and already on the software source
  sequence s_idle;
    reg_addr_i == 8'he8 && reg_rdata_o[7] && !reg_rdata_o[4] && reg_rdata_o[2:0] == 3'h0;
  endsequence
  sequence s_go; reg_wr_i && reg_wdata_i[7:4] == 4'h9 && reg_wdata_i[2:0] == 3'h0; endsequence
  property p_start; s_idle ##0 s_go |=> convert_o [*8]; endproperty
  property p_busy; convert_o && reg_addr_i == 8'he8 |-> reg_rdata_o[4]; endproperty
  property p_irq; irq_o |-> $past(int_enable_i) ##1 !irq_o; endproperty
  property p_done; irq_o && reg_addr_i == 8'he8 |-> reg_rdata_o[5:4] == 2'b10; endproperty
  property p_excl; convert_o |-> !track_o; endproperty
  property p_track; reg_addr_i == 8'he8 && reg_rdata_o[7:6] == 2'b10 && !standby_i
    |-> track_o == !convert_o; endproperty
  property p_standby; standby_i ##1 standby_i |-> !track_o; endproperty
  property p_off; reg_addr_i == 8'he8 |-> power_down_o == !reg_rdata_o[7]; endproperty
  property p_pos; reg_addr_i == 8'hbb |-> reg_rdata_o == {3'h0, positive_input_select_o};
  endproperty
  property p_diff; reg_addr_i == 8'hba |-> differential_o == (reg_rdata_o[4:0] != 5'h1f);
  endproperty
  a_start: assert property (p_start) else $error("software start lost");
  a_busy: assert property (p_busy) else $error("busy low in conversion");
  a_irq: assert property (p_irq) else $error("bad interrupt pulse");
  a_done: assert property (p_done) else $error("done flag not set");
  a_excl: assert property (p_excl) else $error("tracking while converting");
  a_track: assert property (p_track) else $error("default tracking wrong");
  a_standby: assert property (p_standby) else $error("tracking in standby");
  a_off: assert property (p_off) else $error("shutdown level wrong");
  a_pos: assert property (p_pos) else $error("input select read wrong");
  a_diff: assert property (p_diff) else $error("mode wrong");
endmodule

bind sar_adc_conversion_control sar_adc_conversion_control_asserts u_chk (
  .clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .standby_i,
  .int_enable_i, .track_o, .convert_o, .power_down_o, .differential_o,
  .positive_input_select_o, .irq_o);

// File: sim/sar_adc_conversion_control_test.sv
// Self-checking bench for the converter control block.
// Assumes the core model and checker are compiled alongside.
module sar_adc_conversion_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i, rst_i, reg_wr_i, s2, ext, stby, ien, track_o, convert_o, tick, pdn, irq_o;
  logic       dif_o;
  logic [4:0] psel, nsel;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [5:0] tmr;
  logic [9:0] level, code;
  int         failures, num_checks, cycles, last, gap, irqs;
  logic [2:0] srcs [6] = '{3'h1, 3'h3, 3'h2, 3'h2, 3'h5, 3'h5};
  sar_adc_conversion_control u_dut (
    .clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .t0_ovf_i(tmr[0]), .t1_ovf_i(tmr[1]), .t2_low_ovf_i(tmr[2]), .t2_high_ovf_i(tmr[3]),
    .t2_split8_i(s2), .t3_low_ovf_i(tmr[4]), .t3_high_ovf_i(tmr[5]), .t3_split8_i(s2),
    .external_start_input_i(ext), .standby_i(stby), .int_enable_i(ien), .sar_code_i(code),
    .track_o, .convert_o, .sar_clk_en_o(tick), .power_down_o(pdn), .differential_o(dif_o),
    .positive_input_select_o(psel), .negative_input_select_o(nsel), .irq_o);
  sar_core_model u_core (.clk_i, .convert_i(convert_o), .level_i(level), .code_o(code));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Interrupts, tick spacing and hang limit
  always @(negedge clk_i) begin
    cycles++;
    if (irq_o === 1'b1) irqs++;
    if (convert_o === 1'b1 && tick === 1'b1) begin
      if (last >= 0) gap = cycles - last;
      last = cycles;
    end
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    #10 d = reg_rdata_o;
  endtask
  task automatic wait_done(output int n);
    logic [7:0] v;
    n = 0;
    rd(8'he8, v);
    while (v[5] !== 1'b1 && n < 4000) begin
      rd(8'he8, v);
      n++;
    end
  endtask
  task automatic pulse(input int b);
    @(negedge clk_i);
    tmr[b] = 1'b1;
    @(negedge clk_i);
    tmr = 6'h00;
  endtask
  task automatic t_regs();
    logic [7:0] a [7] = '{8'he8, 8'hbc, 8'hbb, 8'hba, 8'hbe, 8'hbd, 8'h80};
    logic [7:0] e [7] = '{8'h00, 8'hf8, 8'h1f, 8'h1f, 8'h00, 8'h00, 8'h00};
    logic [7:0] v;
    for (int i = 0; i < 7; i++) begin
      rd(a[i], v);
      chk("reset value", {8'h00, e[i]}, {8'h00, v});
    end
    wr(8'hbb, 8'hf5);
    rd(8'hbb, v);
    chk("input select", 16'h0015, {8'h00, v});
    chk("positive select", 16'h0015, {11'h000, psel});
  endtask
  task automatic t_track();
    chk("shutdown", 16'h0001, {15'h0, pdn});
    wr(8'he8, 8'h80);
    chk("tracking", 16'h0001, {15'h0, track_o});
    stby = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("standby", 16'h0000, {15'h0, track_o});
    stby = 1'b0;
  endtask
  task automatic t_conv(input logic [4:0] dv, input logic lj, input logic dif,
                        input logic [9:0] c, input logic ie);
    logic [7:0] hi, lo, v;
    logic [15:0] e;
    int n;
    wr(8'hbc, {dv, lj, 2'b00});
    wr(8'hba, dif ? 8'h00 : 8'h1f);
    chk("differential", {15'h0000, dif}, {15'h0000, dif_o});
    chk("negative select", dif ? 16'h0000 : 16'h001f, {11'h000, nsel});
    level = c;
    ien = ie;
    last = -1;
    gap = 0;
    irqs = 0;
    wr(8'he8, 8'h90);
    wait_done(n);
    rd(8'he8, v);
    chk("control", 16'h00a0, {8'h00, v});
    rd(8'hbe, hi);
    rd(8'hbd, lo);
    e = lj ? {c, 6'h00} : (dif ? {{6{c[9]}}, c} : {6'h00, c});
    chk("result", e, {hi, lo});
    chk("tick gap", 16'(dv) + 16'h1, 16'(gap));
    chk("interrupts", 16'(ie), 16'(irqs));
  endtask
  task automatic t_ignore();
    int n1, n2;
    wr(8'hbc, 8'h00);
    wr(8'he8, 8'h90);
    wait_done(n1);
    wr(8'he8, 8'h90);
    repeat (4) @(negedge clk_i);
    wr(8'he8, 8'h90);
    wait_done(n2);
    chk("busy cycles", 16'(n1), 16'(n2 + 6));
  endtask
  task automatic t_timers();
    logic [7:0] v;
    int n;
    for (int i = 0; i < 6; i++) begin
      s2 = ~i[0];
      // Enable only: a busy write here would start on the old source
      wr(8'he8, {5'h10, srcs[i]});
      pulse(i ^ 1);
      rd(8'he8, v);
      chk("no start", 16'h0000, {15'h0, v[4]});
      pulse(i);
      rd(8'he8, v);
      chk("timer start", 16'h0001, {15'h0, v[4]});
      wait_done(n);
    end
  endtask
  task automatic t_ext();
    int n;
    wr(8'he8, 8'hc4);
    repeat (3) @(negedge clk_i);
    chk("track low", 16'h0001, {15'h0, track_o});
    ext = 1'b1;
    @(negedge clk_i);
    chk("sync wait", 16'h0000, {15'h0, convert_o});
    repeat (5) @(negedge clk_i);
    chk("edge start", 16'h0001, {15'h0, convert_o});
    wait_done(n);
    ext = 1'b0;
  endtask
  task automatic t_lowpow();
    int k, n;
    wr(8'hbc, 8'h18);
    // Select the software source before the start write
    wr(8'he8, 8'hc0);
    wr(8'he8, 8'hd0);
    k = 0;
    n = 0;
    while (convert_o !== 1'b1 && n < 200) begin
      k += int'(track_o === 1'b1 && tick === 1'b1);
      n++;
      @(negedge clk_i);
    end
    chk("track ticks", 16'h0003, 16'(k));
    wait_done(n);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {reg_wr_i, s2, ext, stby, ien} = 5'h00;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    tmr = 6'h00;
    level = 10'h000;
    rst_i = 1'b1;
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    t_regs();
    t_track();
    t_conv(5'h00, 1'b0, 1'b0, 10'h3ff, 1'b1);
    t_conv(5'h03, 1'b1, 1'b0, 10'h3ff, 1'b1);
    t_conv(5'h1f, 1'b0, 1'b1, 10'h300, 1'b1);
    t_conv(5'h01, 1'b1, 1'b1, 10'h300, 1'b0);
    t_ignore();
    t_timers();
    t_ext();
    t_lowpow();
    finish_test();
  end
endmodule

// File: sim/sar_core_model.sv
// Analog core stand-in for the converter control block.
// Assumes the bench sets the level before each start.
module sar_core_model (
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       convert_i,
  input  wire logic [9:0] level_i,
  // Code to the block
  output logic      [9:0] code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Code only valid while converting
  always @(posedge clk_i)
    code_o <= convert_i ? level_i : ~level_i;
endmodule

// File: verilog/adc_ctrl_pkg.sv
// Package for the converter control block: register addresses, field positions,
// reset values, start-source codes and timing counts.
// Assumes one 10 MHz system clock and an 8-bit special-register port.
package adc_ctrl_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_POS_SEL  = 8'hbb;
  localparam logic [7:0] ADDR_NEG_SEL  = 8'hba;
  localparam logic [7:0] ADDR_CONFIG   = 8'hbc;
  localparam logic [7:0] ADDR_CONTROL  = 8'he8;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hbe;
  localparam logic [7:0] ADDR_RES_LOW  = 8'hbd;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTL_ENABLE   = 7;
  localparam int CTL_TRACK    = 6;
  localparam int CTL_DONE     = 5;
  localparam int CTL_BUSY     = 4;
  localparam int CTL_SRC_HI   = 2;
  localparam int CFG_DIV_HI   = 7;
  localparam int CFG_DIV_LO   = 3;
  localparam int CFG_LJUST    = 2;
  localparam int SEL_HI       = 4;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [7:0] CONFIG_RESET  = 8'hf8;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [4:0] POS_RESET     = 5'h1f;
  localparam logic [4:0] NEG_RESET     = 5'h1f;
  localparam logic [4:0] NEG_GROUND    = 5'h1f;
  localparam logic [4:0] POS_SUPPLY    = 5'h1f;
  localparam logic [4:0] POS_TEMP      = 5'h1e;

  localparam logic [2:0] SRC_SOFTWARE  = 3'h0;
  localparam logic [2:0] SRC_TIMER0    = 3'h1;
  localparam logic [2:0] SRC_TIMER2    = 3'h2;
  localparam logic [2:0] SRC_TIMER1    = 3'h3;
  localparam logic [2:0] SRC_EXTERNAL  = 3'h4;
  localparam logic [2:0] SRC_TIMER3    = 3'h5;

  // ****************************************************************
  // Timing counts in converter clocks
  // ****************************************************************
  localparam logic [1:0] TRACK_CLOCKS   = 2'h3;
  localparam logic [3:0] CONVERT_CLOCKS = 4'hb;

endpackage

// File: verilog/sar_adc_conversion_control.sv
// Conversion control for a 10-bit successive-approximation converter.
// Assumes a synchronous 8-bit register port, timer overflow pulses and
// an analog core that delivers its 10-bit code when the last bit is decided.

// Contract
// - Converter clock is system clock divided by divider setting plus one.
// - A 3-bit field in the control register picks the start source.
// - Software start: writing 1 to busy starts one conversion.
// - Busy stays 1 through the conversion and clears at its end.
// - Busy falling sets the done flag and raises interrupt if enabled.
// - Result registers are valid once the done flag reads 1.
// - Selected timer 0 to 3 overflow starts a conversion.
// - Timers 2 and 3 use low overflow in 8-bit, high in 16-bit.
// - Selected external start input rising edge starts a conversion.
// - Default tracking: track continuously except during conversion.
// - Low-power tracking: three converter clocks of tracking after each start.
// - Low-power with external start: track while low, convert at rising edge.
// - Tracking can be shut off in standby or sleep.
// - Positive select holds 5 bits, upper three read zero.
// - Converter runs only when enabled, else in shutdown.
// - Ground negative input gives single-ended, anything else differential.
// - Unsigned or two's complement; right-justified differential sign-extends.
// - Divider in config bits 7 to 3, justify select in bit 2.
module sar_adc_conversion_control (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Trigger sources
  input  wire logic       t0_ovf_i,
  input  wire logic       t1_ovf_i,
  input  wire logic       t2_low_ovf_i,
  input  wire logic       t2_high_ovf_i,
  input  wire logic       t2_split8_i,
  input  wire logic       t3_low_ovf_i,
  input  wire logic       t3_high_ovf_i,
  input  wire logic       t3_split8_i,
  input  wire logic       external_start_input_i,
  // System
  input  wire logic       standby_i,
  input  wire logic       int_enable_i,
  // Analog core
  input  wire logic [9:0] sar_code_i,
  output logic            track_o,
  output logic            convert_o,
  output logic            sar_clk_en_o,
  output logic            power_down_o,
  output logic            differential_o,
  output logic      [4:0] positive_input_select_o,
  output logic      [4:0] negative_input_select_o,
  // Interrupt
  output logic            irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONV  = 3'b100
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [7:0]  control;
    logic [7:0]  config_;
    logic [4:0]  pos_sel;
    logic [4:0]  neg_sel;
    logic [15:0] result;
    logic [3:0]  count;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_prev;
    logic        irq;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic       tick;

  // Sign-extend or zero-fill a code into the two result bytes
  function automatic logic [15:0] format_code(input logic [9:0] code,
                                              input logic diff, input logic ljust);
    if (ljust) begin
      format_code = {code, 6'h00};
    end else if (diff) begin
      format_code = {{6{code[9]}}, code};
    end else begin
      format_code = {6'h00, code};
    end
  endfunction

  sar_clk_div u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (st_r.control[adc_ctrl_pkg::CTL_ENABLE]),
    .div_i  (st_r.config_[adc_ctrl_pkg::CFG_DIV_HI:adc_ctrl_pkg::CFG_DIV_LO]),
    .tick_o (tick)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic       enabled;
  logic       low_power;
  logic [2:0] src;
  logic       ext_rise;
  logic       sw_start;
  logic       trigger;
  logic       t2_ovf;
  logic       t3_ovf;
  logic       diff;

  always_comb begin
    st_nxt    = st_r;
    enabled   = st_r.control[adc_ctrl_pkg::CTL_ENABLE];
    low_power = st_r.control[adc_ctrl_pkg::CTL_TRACK];
    src       = st_r.control[adc_ctrl_pkg::CTL_SRC_HI:0];
    diff      = (st_r.neg_sel != adc_ctrl_pkg::NEG_GROUND);
    // Second stage feeds the edge detector and the low-power external tracking
    st_nxt.ext_s1   = external_start_input_i;
    st_nxt.ext_s2   = st_r.ext_s1;
    st_nxt.ext_prev = st_r.ext_s2;
    ext_rise = st_r.ext_s2 && !st_r.ext_prev;
    t2_ovf   = t2_split8_i ? t2_low_ovf_i : t2_high_ovf_i;
    t3_ovf   = t3_split8_i ? t3_low_ovf_i : t3_high_ovf_i;
    sw_start = reg_wr_i && reg_addr_i == adc_ctrl_pkg::ADDR_CONTROL
               && reg_wdata_i[adc_ctrl_pkg::CTL_BUSY];
    unique case (src)
      adc_ctrl_pkg::SRC_SOFTWARE: trigger = sw_start;
      adc_ctrl_pkg::SRC_TIMER0:   trigger = t0_ovf_i;
      adc_ctrl_pkg::SRC_TIMER2:   trigger = t2_ovf;
      adc_ctrl_pkg::SRC_TIMER1:   trigger = t1_ovf_i;
      adc_ctrl_pkg::SRC_EXTERNAL: trigger = ext_rise;
      adc_ctrl_pkg::SRC_TIMER3:   trigger = t3_ovf;
      default:                    trigger = 1'b0;
    endcase
    st_nxt.irq = 1'b0;

    // Register writes; busy keeps its value, done takes the written bit; both are hardware driven below
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        adc_ctrl_pkg::ADDR_CONTROL: begin
          st_nxt.control = {reg_wdata_i[7:6], reg_wdata_i[adc_ctrl_pkg::CTL_DONE],
                            st_r.control[adc_ctrl_pkg::CTL_BUSY], reg_wdata_i[3:0]};
        end
        adc_ctrl_pkg::ADDR_CONFIG:  st_nxt.config_ = reg_wdata_i;
        adc_ctrl_pkg::ADDR_POS_SEL: st_nxt.pos_sel = reg_wdata_i[adc_ctrl_pkg::SEL_HI:0];
        adc_ctrl_pkg::ADDR_NEG_SEL: st_nxt.neg_sel = reg_wdata_i[adc_ctrl_pkg::SEL_HI:0];
        default: ;
      endcase
    end

    unique case (st_r.phase)
      ST_IDLE: begin
        // Triggers while busy never reach here
        if (enabled && trigger) begin
          st_nxt.control[adc_ctrl_pkg::CTL_BUSY] = 1'b1;
          st_nxt.count = 4'h0;
          if (low_power && src != adc_ctrl_pkg::SRC_EXTERNAL) begin
            st_nxt.phase = ST_TRACK;
          end else begin
            st_nxt.phase = ST_CONV;
          end
        end
      end
      ST_TRACK: begin
        if (tick) begin
          st_nxt.count = st_r.count + 4'h1;
          if (st_r.count[1:0] == adc_ctrl_pkg::TRACK_CLOCKS - 2'h1) begin
            st_nxt.count = 4'h0;
            st_nxt.phase = ST_CONV;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          st_nxt.count = st_r.count + 4'h1;
          if (st_r.count == adc_ctrl_pkg::CONVERT_CLOCKS - 4'h1) begin
            st_nxt.result = format_code(sar_code_i, diff,
                                        st_r.config_[adc_ctrl_pkg::CFG_LJUST]);
            st_nxt.control[adc_ctrl_pkg::CTL_BUSY] = 1'b0;
            st_nxt.control[adc_ctrl_pkg::CTL_DONE] = 1'b1;
            st_nxt.irq   = int_enable_i;
            st_nxt.phase = ST_IDLE;
          end
        end
      end
      default: st_nxt.phase = ST_IDLE;
    endcase

    if (!enabled) begin
      st_nxt.phase = ST_IDLE;
      st_nxt.control[adc_ctrl_pkg::CTL_BUSY] = 1'b0;
    end
  end

  // ****************************************************************
  // Registers and outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r         <= '0;
      st_r.phase   <= ST_IDLE;
      st_r.control <= adc_ctrl_pkg::CONTROL_RESET;
      st_r.config_ <= adc_ctrl_pkg::CONFIG_RESET;
      st_r.pos_sel <= adc_ctrl_pkg::POS_RESET;
      st_r.neg_sel <= adc_ctrl_pkg::NEG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    unique case (reg_addr_i)
      adc_ctrl_pkg::ADDR_CONTROL:  reg_rdata_o = st_r.control;
      adc_ctrl_pkg::ADDR_CONFIG:   reg_rdata_o = st_r.config_;
      adc_ctrl_pkg::ADDR_POS_SEL:  reg_rdata_o = {3'h0, st_r.pos_sel};
      adc_ctrl_pkg::ADDR_NEG_SEL:  reg_rdata_o = {3'h0, st_r.neg_sel};
      adc_ctrl_pkg::ADDR_RES_HIGH: reg_rdata_o = st_r.result[15:8];
      adc_ctrl_pkg::ADDR_RES_LOW:  reg_rdata_o = st_r.result[7:0];
      default:                     reg_rdata_o = 8'h00;
    endcase
  end

  // Track when enabled, awake and in the track phase or idle; low-power idle tracks only on external source with input low
  assign track_o = st_r.control[adc_ctrl_pkg::CTL_ENABLE] && !standby_i
                   && (st_r.phase == ST_TRACK
                       || (st_r.phase == ST_IDLE && !st_r.control[adc_ctrl_pkg::CTL_TRACK])
                       || (st_r.phase == ST_IDLE && st_r.control[adc_ctrl_pkg::CTL_TRACK]
                           && st_r.control[2:0] == adc_ctrl_pkg::SRC_EXTERNAL
                           && !st_r.ext_s2));
  assign convert_o               = (st_r.phase == ST_CONV);
  assign sar_clk_en_o            = tick;
  assign power_down_o            = !st_r.control[adc_ctrl_pkg::CTL_ENABLE];
  assign differential_o          = (st_r.neg_sel != adc_ctrl_pkg::NEG_GROUND);
  assign positive_input_select_o = st_r.pos_sel;
  assign negative_input_select_o = st_r.neg_sel;
  assign irq_o                   = st_r.irq;

endmodule

// File: verilog/sar_clk_div.sv
// Converter clock divider: one-cycle enable every (setting + 1) system clocks.
// Assumes the setting is a stable register value.
module sar_clk_div (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [4:0] div_i,
  // Enable
  output logic            tick_o
);

  typedef struct packed {
    logic [4:0] cnt;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!run_i || st_r.cnt >= div_i) begin
      st_nxt.cnt = 5'h00;
    end else begin
      st_nxt.cnt = st_r.cnt + 5'h01;
    end
  end

  assign tick_o = run_i && (st_r.cnt >= div_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
